// ---- arith_unit_defines.vh ----
// Constants shared by the arithmetic and logic execution unit.
`ifndef ARITH_UNIT_DEFINES_VH
`define ARITH_UNIT_DEFINES_VH

// ------
// Machine cycle timing
// ------
`define MC_LAST       4'd3

// ------
// Architectural register locations in the direct address space
// ------
`define SFR_BASE      8'h80
`define ADDR_ACC      8'he0
`define ADDR_B        8'hf0
`define ADDR_PSW      8'hd0
`define ADDR_DPL      8'h82
`define ADDR_DPH      8'h83

// ------
// Status word fields and reset values
// ------
`define PSW_C         7
`define PSW_AC        6
`define PSW_RS1       4
`define PSW_RS0       3
`define PSW_OV        2
`define PSW_RST       8'h00
`define ACC_RST       8'h00
`define B_RST         8'h00
`define DATA_POINTER_REG_RST      16'h0000

// ------
// Operation codes of the combinational unit
// ------
`define ALU_PASS      5'h00
`define ALU_ADD       5'h01
`define ALU_SUM_WITH_CARRY_INTO_ACC      5'h02
`define ALU_DIFFERENCE_WITH_BORROW      5'h03
`define ALU_AND       5'h04
`define ALU_OR        5'h05
`define ALU_XOR       5'h06
`define ALU_INC       5'h07
`define ALU_DEC       5'h08
`define ALU_MUL       5'h09
`define ALU_DIV       5'h0a
`define ALU_DA        5'h0b
`define ALU_CLR       5'h0c
`define ALU_CPL       5'h0d
`define ALU_SWAP      5'h0e
`define ALU_RL        5'h0f
`define ALU_RLC       5'h10
`define ALU_RR        5'h11
`define ALU_RRC       5'h12

// ------
// Instruction encodings
// ------
`define HI_INC        4'h0
`define HI_DEC        4'h1
`define HI_ADD        4'h2
`define HI_SUM_WITH_CARRY_INTO_ACC       4'h3
`define HI_ORL        4'h4
`define HI_ANL        4'h5
`define HI_XRL        4'h6
`define HI_DIFFERENCE_WITH_BORROW       4'h9
`define LO_DIR_ACC    4'h2
`define LO_DIR_IMM    4'h3
`define LO_IMM        4'h4
`define LO_DIR        4'h5
`define LO_RN         4'h8
`define OPC_NOP       8'h00
`define OPC_INC_DATA_POINTER_REG  8'ha3
`define OPC_MUL       8'ha4
`define OPC_DIV       8'h84
`define OPC_DA        8'hd4
`define OPC_CLR       8'he4
`define OPC_CPL       8'hf4
`define OPC_SWAP      8'hc4
`define OPC_RL        8'h23
`define OPC_RLC       8'h33
`define OPC_RR        8'h03
`define OPC_RRC       8'h13

// ------
// Sizes, cycle counts and decimal adjust constants
// ------
`define SZ_1          2'd1
`define SZ_2          2'd2
`define SZ_3          2'd3
`define CY_1          3'd1
`define CY_2          3'd2
`define CY_4          3'd4
`define BCD_LIM       4'h9
`define BCD_LO        9'h006
`define BCD_HI        9'h060

`endif

// ---- arith_logic_core.v ----
// Combinational arithmetic and logic unit with flag generation.
`timescale 1ns/1ps
`include "arith_unit_defines.vh"

module arith_logic_core (
    input  wire [4:0] op,
    input  wire [7:0] a,
    input  wire [7:0] s,
    input  wire [7:0] b,
    input  wire       cin,
    input  wire       acin,
    input  wire       ovin,
    output reg  [7:0] res,
    output reg  [7:0] bres,
    output reg        cout,
    output reg        acout,
    output reg        ovout
);

    reg        cy;
    reg  [8:0] wide;
    reg  [4:0] nib;
    reg  [15:0] prod;

    always @* begin
        cy    = 1'b0;
        wide  = 9'h000;
        nib   = 5'h00;
        prod  = 16'h0000;
        res   = a;
        bres  = b;
        cout  = cin;
        acout = acin;
        ovout = ovin;
        case (op)
            `ALU_ADD, `ALU_SUM_WITH_CARRY_INTO_ACC: begin
                cy    = (op == `ALU_SUM_WITH_CARRY_INTO_ACC) ? cin : 1'b0; // [RULE_05]
                wide  = {1'b0, a} + {1'b0, s} + {8'h00, cy}; // [RULE_04]
                nib   = {1'b0, a[3:0]} + {1'b0, s[3:0]} + {4'h0, cy};
                res   = wide[7:0];
                cout  = wide[8];
                acout = nib[4];
                ovout = (a[7] == s[7]) && (wide[7] != a[7]);
            end
            `ALU_DIFFERENCE_WITH_BORROW: begin
                wide  = {1'b0, a} - {1'b0, s} - {8'h00, cin}; // [RULE_06]
                nib   = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, cin};
                res   = wide[7:0];
                cout  = wide[8];
                acout = nib[4];
                ovout = (a[7] != s[7]) && (wide[7] != a[7]);
            end
            `ALU_AND:  res = a & s;
            `ALU_OR:   res = a | s;
            `ALU_XOR:  res = a ^ s;
            `ALU_INC:  res = a + 8'h01;
            `ALU_DEC:  res = a - 8'h01;
            `ALU_MUL: begin
                prod  = a * b;
                res   = prod[7:0];
                bres  = prod[15:8];
                cout  = 1'b0;
                ovout = |prod[15:8];
            end
            `ALU_DIV: begin
                // A zero divisor leaves both operands unchanged and flags it.
                cout  = 1'b0;
                ovout = (b == 8'h00);
                if (b != 8'h00) begin
                    res  = a / b;
                    bres = a % b;
                end
            end
            `ALU_DA: begin
                wide = {1'b0, a};
                if ((a[3:0] > `BCD_LIM) || acin) begin
                    wide = wide + `BCD_LO;
                end
                cy = cin | wide[8];
                if ((wide[7:4] > `BCD_LIM) || cy) begin
                    wide = {1'b0, wide[7:0]} + `BCD_HI;
                end
                res  = wide[7:0];
                cout = cy | wide[8];
            end
            `ALU_CLR:  res = 8'h00;
            `ALU_CPL:  res = ~a;
            `ALU_SWAP: res = {a[3:0], a[7:4]};
            `ALU_RL:   res = {a[6:0], a[7]};
            `ALU_RR:   res = {a[0], a[7:1]};
            `ALU_RLC: begin
                res  = {a[6:0], cin}; // [RULE_15]
                cout = a[7];
            end
            `ALU_RRC: begin
                res  = {cin, a[7:1]}; // [RULE_14]
                cout = a[0];
            end
            default:   res = a;
        endcase
    end

endmodule

// ---- arith_logic_instruction_unit.v ----
// Execution unit for the arithmetic and logical instruction group.
// Summary of operation
// RULE_01: Opcodes use the standard encodings of this instruction set with standard results.
// RULE_02: An indirect operand takes its address from R0 or R1 of the current bank.
// RULE_03: A relative displacement is a signed two's complement byte added to the next address.
// RULE_04: Add takes one byte for register or indirect and two for direct or immediate, one cycle.
// RULE_05: Add with carry sums accumulator, operand and carry with the same sizes and cycles.
// RULE_06: Subtract with borrow removes operand and carry from A in one cycle, one byte for registers.
// RULE_07: Subtract with borrow of an immediate is two bytes and one cycle.
// RULE_08: Subtract with borrow through the pointer reads internal memory, one byte, one cycle.
// RULE_09: AND of an immediate into a direct byte writes it back, three bytes, two cycles.
// RULE_10: OR of an immediate into a direct byte writes it back, three bytes, two cycles.
// RULE_11: XOR of an immediate into a direct byte writes it back, three bytes, two cycles.
// RULE_12: XOR of a bank register into A stores in A, one byte, one cycle.
// RULE_13: AND of A into a direct byte stores at the direct address, two bytes.
// RULE_14: Rotate right via carry moves bit 0 to carry and carry to bit 7, one byte, one cycle.
// RULE_15: Rotate left via carry moves bit 7 to carry and carry to bit 0, one byte.
// RULE_16: Multiply and divide are one byte held four cycles; pointer increment takes two.
// RULE_17: Single-cycle accumulator operations finish in one cycle and touch only their operand.
`timescale 1ns/1ps
`include "arith_unit_defines.vh"

module arith_logic_instruction_unit (
    input  wire        clock,
    input  wire        rst,
    input  wire        start,
    input  wire [7:0]  opcode,
    input  wire [7:0]  operand1,
    input  wire [7:0]  operand2,
    input  wire [15:0] pc_next,
    input  wire        load_en,
    input  wire [7:0]  load_addr,
    input  wire [7:0]  load_data,
    input  wire [7:0]  peek_addr,
    output reg         busy,
    output reg         done,
    output reg         bad_opcode,
    output reg  [1:0]  instr_bytes,
    output reg  [2:0]  instr_cycles,
    output reg  [15:0] rel_target,
    output reg  [7:0]  acc,
    output reg  [7:0]  b_reg,
    output reg  [7:0]  psw,
    output reg  [15:0] data_pointer_reg,
    output reg  [7:0]  peek_data
);

    // ------
    // State
    // ------
    localparam S_IDLE = 2'b01;
    localparam S_EXEC = 2'b10;

    reg [1:0]  state;
    reg [3:0]  mc_count;
    reg [2:0]  remaining;
    reg [7:0]  op_q;
    reg [7:0]  opnd1_q;
    reg [7:0]  opnd2_q;
    reg [11:0] info_q;
    reg [7:0]  ram [0:255];

    wire       mc_tick = (mc_count == `MC_LAST);
    wire       exec    = state[1] && mc_tick && (remaining == `CY_1);

    // ------
    // Decode: {valid, alu op, size, cycles, destination is A}
    // ------
    function [11:0] decode;
        input [7:0] op;
        reg   [3:0] hi;
        reg   [3:0] lo;
        reg   [1:0] sz;
        begin
            hi = op[7:4];
            lo = op[3:0];
            sz = ((lo == `LO_IMM) || (lo == `LO_DIR)) ? `SZ_2 : `SZ_1; // [RULE_04]
            decode = {1'b0, `ALU_PASS, `SZ_1, `CY_1, 1'b1};
            if (op == `OPC_NOP) begin
                decode = {1'b1, `ALU_PASS, `SZ_1, `CY_1, 1'b1};
            end else if (op == `OPC_INC_DATA_POINTER_REG) begin
                decode = {1'b1, `ALU_PASS, `SZ_1, `CY_2, 1'b1}; // [RULE_16]
            end else if (op == `OPC_MUL) begin
                decode = {1'b1, `ALU_MUL, `SZ_1, `CY_4, 1'b1}; // [RULE_16]
            end else if (op == `OPC_DIV) begin
                decode = {1'b1, `ALU_DIV, `SZ_1, `CY_4, 1'b1}; // [RULE_16]
            end else if (op == `OPC_DA) begin
                decode = {1'b1, `ALU_DA, `SZ_1, `CY_1, 1'b1};
            end else if (op == `OPC_CLR) begin
                decode = {1'b1, `ALU_CLR, `SZ_1, `CY_1, 1'b1}; // [RULE_17]
            end else if (op == `OPC_CPL) begin
                decode = {1'b1, `ALU_CPL, `SZ_1, `CY_1, 1'b1}; // [RULE_17]
            end else if (op == `OPC_SWAP) begin
                decode = {1'b1, `ALU_SWAP, `SZ_1, `CY_1, 1'b1}; // [RULE_17]
            end else if (op == `OPC_RL) begin
                decode = {1'b1, `ALU_RL, `SZ_1, `CY_1, 1'b1}; // [RULE_17]
            end else if (op == `OPC_RR) begin
                decode = {1'b1, `ALU_RR, `SZ_1, `CY_1, 1'b1}; // [RULE_17]
            end else if (op == `OPC_RLC) begin
                decode = {1'b1, `ALU_RLC, `SZ_1, `CY_1, 1'b1}; // [RULE_15]
            end else if (op == `OPC_RRC) begin
                decode = {1'b1, `ALU_RRC, `SZ_1, `CY_1, 1'b1}; // [RULE_14]
            end else if (lo >= `LO_IMM) begin
                if (hi == `HI_ADD) begin
                    decode = {1'b1, `ALU_ADD, sz, `CY_1, 1'b1}; // [RULE_04]
                end else if (hi == `HI_SUM_WITH_CARRY_INTO_ACC) begin
                    decode = {1'b1, `ALU_SUM_WITH_CARRY_INTO_ACC, sz, `CY_1, 1'b1}; // [RULE_05]
                end else if (hi == `HI_DIFFERENCE_WITH_BORROW) begin
                    decode = {1'b1, `ALU_DIFFERENCE_WITH_BORROW, sz, `CY_1, 1'b1}; // [RULE_06] [RULE_07] [RULE_08]
                end else if (hi == `HI_ANL) begin
                    decode = {1'b1, `ALU_AND, sz, `CY_1, 1'b1};
                end else if (hi == `HI_ORL) begin
                    decode = {1'b1, `ALU_OR, sz, `CY_1, 1'b1};
                end else if (hi == `HI_XRL) begin
                    decode = {1'b1, `ALU_XOR, sz, `CY_1, 1'b1}; // [RULE_12]
                end else if (hi == `HI_INC) begin
                    decode = {1'b1, `ALU_INC, sz, `CY_1, lo == `LO_IMM}; // [RULE_17]
                end else if (hi == `HI_DEC) begin
                    decode = {1'b1, `ALU_DEC, sz, `CY_1, lo == `LO_IMM}; // [RULE_17]
                end
            end else if ((lo == `LO_DIR_ACC) || (lo == `LO_DIR_IMM)) begin
                sz = (lo == `LO_DIR_IMM) ? `SZ_3 : `SZ_2;
                if (hi == `HI_ANL) begin
                    decode = {1'b1, `ALU_AND, sz, lo == `LO_DIR_IMM ? `CY_2 : `CY_1,
                              1'b0}; // [RULE_09] [RULE_13]
                end else if (hi == `HI_ORL) begin
                    decode = {1'b1, `ALU_OR, sz, lo == `LO_DIR_IMM ? `CY_2 : `CY_1,
                              1'b0}; // [RULE_10]
                end else if (hi == `HI_XRL) begin
                    decode = {1'b1, `ALU_XOR, sz, lo == `LO_DIR_IMM ? `CY_2 : `CY_1,
                              1'b0}; // [RULE_11]
                end
            end
        end
    endfunction

    // ------
    // Operand access
    // ------
    // Direct addresses below the SFR base are RAM; above it only the
    // architectural registers answer, anything else reads as zero.
    function [7:0] rd_dir(input [7:0] ad, input [7:0] mem, input [7:0] av,
                          input [7:0] bv, input [7:0] pv, input [15:0] dv);
        begin
            if (ad < `SFR_BASE) begin
                rd_dir = mem;
            end else if (ad == `ADDR_ACC) begin
                rd_dir = av;
            end else if (ad == `ADDR_B) begin
                rd_dir = bv;
            end else if (ad == `ADDR_PSW) begin
                rd_dir = pv;
            end else if (ad == `ADDR_DPL) begin
                rd_dir = dv[7:0];
            end else if (ad == `ADDR_DPH) begin
                rd_dir = dv[15:8];
            end else begin
                rd_dir = 8'h00;
            end
        end
    endfunction

    wire [11:0] dec_in  = decode(opcode);
    wire [3:0] lo       = op_q[3:0];
    wire [7:0] rn_addr  = {3'b000, psw[`PSW_RS1:`PSW_RS0], lo[2:0]};
    wire [7:0] ptr_addr = {3'b000, psw[`PSW_RS1:`PSW_RS0], 2'b00, lo[0]}; // [RULE_02]
    wire [7:0] ind_addr = ram[ptr_addr]; // [RULE_02] [RULE_08]
    wire [7:0] loc_val  = (lo >= `LO_RN) ? ram[rn_addr] :
                          (lo == `LO_IMM) ? opnd1_q :
                          (lo > `LO_DIR) ? ram[ind_addr] :
                          rd_dir(opnd1_q, ram[opnd1_q], acc, b_reg, psw, data_pointer_reg);
    wire       to_acc   = info_q[0];
    wire [4:0] alu_op   = info_q[10:6];
    wire [7:0] alu_a    = to_acc ? acc : loc_val;
    wire [7:0] alu_s    = to_acc ? loc_val :
                          (lo == `LO_DIR_IMM) ? opnd2_q :
                          (lo == `LO_DIR_ACC) ? acc : loc_val;
    wire [7:0] alu_res;
    wire [7:0] alu_bres;
    wire       alu_c;
    wire       alu_ac;
    wire       alu_ov;

    arith_logic_core u_core (
        .op    (alu_op),
        .a     (alu_a),
        .s     (alu_s),
        .b     (b_reg),
        .cin   (psw[`PSW_C]),
        .acin  (psw[`PSW_AC]),
        .ovin  (psw[`PSW_OV]),
        .res   (alu_res),
        .bres  (alu_bres),
        .cout  (alu_c),
        .acout (alu_ac),
        .ovout (alu_ov)
    );

    // ------
    // Next-state computation
    // ------
    reg [7:0]  next_acc;
    reg [7:0]  next_b;
    reg [7:0]  next_psw;
    reg [15:0] next_data_pointer_reg;
    reg        ram_we;
    reg [7:0]  ram_wa;
    reg [7:0]  ram_wd;

    task put_direct;
        input [7:0] ad;
        input [7:0] val;
        begin
            if (ad < `SFR_BASE) begin
                ram_we = 1'b1;
                ram_wa = ad;
                ram_wd = val;
            end else if (ad == `ADDR_ACC) begin
                next_acc = val;
            end else if (ad == `ADDR_B) begin
                next_b = val;
            end else if (ad == `ADDR_PSW) begin
                next_psw = val;
            end else if (ad == `ADDR_DPL) begin
                next_data_pointer_reg[7:0] = val;
            end else if (ad == `ADDR_DPH) begin
                next_data_pointer_reg[15:8] = val;
            end
        end
    endtask

    always @* begin
        next_acc  = acc;
        next_b    = b_reg;
        next_psw  = psw;
        next_data_pointer_reg = data_pointer_reg;
        ram_we    = 1'b0;
        ram_wa    = 8'h00;
        ram_wd    = 8'h00;
        if (load_en && !busy) begin
            put_direct(load_addr, load_data);
        end else if (exec && info_q[11]) begin
            next_b             = alu_bres;
            next_psw[`PSW_C]   = alu_c;
            next_psw[`PSW_AC]  = alu_ac;
            next_psw[`PSW_OV]  = alu_ov;
            if (op_q == `OPC_INC_DATA_POINTER_REG) begin
                next_data_pointer_reg = data_pointer_reg + 16'h0001; // [RULE_16]
            end
            if (to_acc) begin
                next_acc = alu_res; // [RULE_05] [RULE_12] [RULE_17]
            end else if ((lo >= `LO_DIR_ACC) && (lo <= `LO_DIR)) begin
                put_direct(opnd1_q, alu_res); // [RULE_09] [RULE_10] [RULE_11] [RULE_13]
            end else if (lo >= `LO_RN) begin
                ram_we = 1'b1;
                ram_wa = rn_addr;
                ram_wd = alu_res;
            end else begin
                ram_we = 1'b1;
                ram_wa = ind_addr; // [RULE_02]
                ram_wd = alu_res;
            end
        end
    end

    // ------
    // Sequencer and registers
    // ------
    // The machine-cycle divider restarts on each accepted instruction so
    // that completion lands a fixed number of clocks after the start.
    always @(posedge clock) begin
        if (rst) begin
            state            <= S_IDLE;
            mc_count         <= 4'd0;
            remaining        <= 3'd0;
            op_q             <= 8'h00;
            opnd1_q          <= 8'h00;
            opnd2_q          <= 8'h00;
            info_q           <= 12'h000;
            busy             <= 1'b0;
            done             <= 1'b0;
            bad_opcode       <= 1'b0;
            instr_bytes      <= 2'd0;
            instr_cycles     <= 3'd0;
            rel_target       <= 16'h0000;
            acc              <= `ACC_RST;
            b_reg            <= `B_RST;
            psw              <= `PSW_RST;
            data_pointer_reg <= `DATA_POINTER_REG_RST;
            peek_data        <= 8'h00;
        end else begin
            done       <= 1'b0;
            bad_opcode <= 1'b0;
            mc_count   <= mc_tick ? 4'd0 : mc_count + 4'd1;
            peek_data  <= rd_dir(peek_addr, ram[peek_addr], acc, b_reg, psw, data_pointer_reg);
            acc        <= next_acc;
            b_reg      <= next_b;
            psw        <= {next_psw[7:1], ^next_acc};
            data_pointer_reg <= next_data_pointer_reg;
            case (state)
                S_IDLE: begin
                    if (start) begin
                        state        <= S_EXEC;
                        busy         <= 1'b1;
                        mc_count     <= 4'd0;
                        op_q         <= opcode;
                        opnd1_q      <= operand1;
                        opnd2_q      <= operand2;
                        info_q       <= dec_in; // [RULE_01]
                        remaining    <= dec_in[3:1];
                        instr_bytes  <= dec_in[5:4];
                        instr_cycles <= dec_in[3:1];
                        rel_target   <= pc_next + {{8{operand1[7]}}, operand1}; // [RULE_03]
                    end
                end
                S_EXEC: begin
                    if (exec) begin
                        state      <= S_IDLE;
                        busy       <= 1'b0;
                        done       <= 1'b1;
                        bad_opcode <= ~info_q[11];
                    end else if (mc_tick) begin
                        remaining <= remaining - 3'd1; // [RULE_16]
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Internal RAM has no reset; software or the load port initialises it.
    always @(posedge clock) begin
        if (ram_we) begin
            ram[ram_wa] <= ram_wd;
        end
    end

endmodule

// ---- alu_port_checker.sv ----
// Concurrent checks on the ports of the arithmetic instruction unit.
`timescale 1ns/1ps
module alu_port_checker (
    input logic        clock,
    input logic        rst,
    input logic        start,
    input logic [7:0]  opcode,
    input logic [7:0]  operand1,
    input logic [15:0] pc_next,
    input logic        busy,
    input logic        done,
    input logic [1:0]  instr_bytes,
    input logic [2:0]  instr_cycles,
    input logic [15:0] rel_target,
    input logic [7:0]  acc,
    input logic [7:0]  psw
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ------
    // Helper logic
    // ------
    logic [4:0] cnt;
    always @(posedge clock) begin
        if (rst || (start && !busy))
            cnt <= 5'h00;
        else if (busy)
            cnt <= cnt + 5'h01;
    end
    sequence s_take(logic [7:0] o);
        start && !busy && opcode == o;
    endsequence
    sequence s_run(logic [7:0] o);
        s_take(o) ##1 busy [*4] ##1 done;
    endsequence
    property p_size(logic [7:0] o, logic [1:0] nb, logic [2:0] nc);
        s_take(o) |=> instr_bytes == nb && instr_cycles == nc;
    endproperty
    // ------
    // Assertions
    // ------
    AST_TIMING: assert property (done |-> cnt == {instr_cycles, 2'b00})
        else $error("done off the machine cycle count");
    AST_ADD_SIZE: assert property (p_size(8'h24, 2'd2, 3'd1))
        else $error("add immediate size or cycles wrong");
    AST_DIFFERENCE_WITH_BORROW_IMM: assert property (p_size(8'h94, 2'd2, 3'd1))
        else $error("subtract immediate size or cycles wrong");
    AST_DIFFERENCE_WITH_BORROW_IND: assert property (p_size(8'h96, 2'd1, 3'd1))
        else $error("subtract indirect size or cycles wrong");
    AST_AND_DIR: assert property (p_size(8'h53, 2'd3, 3'd2))
        else $error("and direct immediate size or cycles wrong");
    AST_OR_DIR: assert property (p_size(8'h43, 2'd3, 3'd2))
        else $error("or direct immediate size or cycles wrong");
    AST_XOR_DIR: assert property (p_size(8'h63, 2'd3, 3'd2))
        else $error("xor direct immediate size or cycles wrong");
    AST_AND_ACC: assert property (p_size(8'h52, 2'd2, 3'd1))
        else $error("and direct accumulator size wrong");
    AST_MUL: assert property (p_size(8'ha4, 2'd1, 3'd4))
        else $error("multiply size or cycles wrong");
    AST_REL: assert property (start && !busy |=> rel_target ==
        $past(pc_next) + {{8{$past(operand1[7])}}, $past(operand1)})
        else $error("relative target wrong");
    AST_RRC: assert property (s_run(8'h13) |-> acc ==
        {$past(psw[7], 4), $past(acc[7:1], 4)} && psw[7] == $past(acc[0], 4))
        else $error("rotate right via carry wrong");
    AST_RLC: assert property (s_run(8'h33) |-> acc ==
        {$past(acc[6:0], 4), $past(psw[7], 4)} && psw[7] == $past(acc[7], 4))
        else $error("rotate left via carry wrong");
    AST_PARITY: assert property (psw[0] == ^acc)
        else $error("parity flag out of step with accumulator");
endmodule

// ---- arith_logic_instruction_unit_tb.sv ----
// Self-checking testbench for the arithmetic instruction unit.
`timescale 1ns/1ps
module arith_logic_instruction_unit_tb;
    logic        clock = 1'b0, rst = 1'b1, start = 1'b0, load_en = 1'b0;
    logic [7:0]  opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00;
    logic [7:0]  load_addr = 8'h00, load_data = 8'h00, peek_addr = 8'h00;
    logic [15:0] pc_next = 16'h0000, rel_target, data_pointer_reg;
    logic [7:0]  acc, b_reg, psw, peek_data, acc_m, b_m, d, ram_m [0:255];
    logic        busy, done, bad_opcode, c_m;
    logic [1:0]  instr_bytes;
    logic [2:0]  instr_cycles;
    logic [30:0] notes [$];
    logic [30:0] exp_v, seen;
    logic [7:0]  ops [21] = '{8'h24, 8'h25, 8'h26, 8'h2b, 8'h34, 8'h35, 8'h37, 8'h39, 8'h94,
        8'h95, 8'h96, 8'h9f, 8'h53, 8'h43, 8'h63, 8'h52, 8'h6a, 8'h13, 8'h33, 8'ha4, 8'h80};
    int          failures = 0, check_count = 0;
    arith_logic_instruction_unit dut (.clock(clock), .rst(rst), .start(start), .opcode(opcode),
        .operand1(operand1), .operand2(operand2), .pc_next(pc_next), .load_en(load_en),
        .load_addr(load_addr), .load_data(load_data), .peek_addr(peek_addr), .busy(busy),
        .done(done), .bad_opcode(bad_opcode), .instr_bytes(instr_bytes),
        .instr_cycles(instr_cycles), .rel_target(rel_target), .acc(acc), .b_reg(b_reg),
        .psw(psw), .data_pointer_reg(data_pointer_reg), .peek_data(peek_data));
    always #5 clock = ~clock;
    // ------
    // Tasks
    // ------
    task automatic check(input logic [30:0] got, input logic [30:0] want);
        check_count++;
        if (got !== want) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic load(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        load_en = 1'b1;
        load_addr = a;
        load_data = v;
    endtask
    task automatic issue(input logic [7:0] op);
        logic [7:0] o1, o2, src;
        logic [1:0] nb;
        logic [2:0] nc;
        logic       bad;
        int         n;
        o1 = (op[3:0] == 4'h4) ? 8'($urandom) : 8'(8 + $urandom % 120);
        o2 = 8'($urandom);
        nb = 2'd1;
        nc = 3'd1;
        bad = 1'b0;
        case (op[3:0])
            4'h4: src = o1;
            4'h5: src = ram_m[o1];
            4'h6, 4'h7: src = ram_m[ram_m[op[0]]];
            default: src = ram_m[op[2:0]];
        endcase
        if ((op[3:0] inside {4'h4, 4'h5} && op < 8'ha0) || op == 8'h52)
            nb = 2'd2;
        case (op)
            8'h53, 8'h43, 8'h63: begin
                nb = 2'd3;
                nc = 3'd2;
                ram_m[o1] = op == 8'h53 ? ram_m[o1] & o2 : op == 8'h43 ? ram_m[o1] | o2
                    : ram_m[o1] ^ o2;
            end
            8'h52: ram_m[o1] = ram_m[o1] & acc_m;
            8'h13: {acc_m, c_m} = {c_m, acc_m};
            8'h33: {c_m, acc_m} = {acc_m, c_m};
            8'ha4: begin
                nc = 3'd4;
                {b_m, acc_m} = acc_m * b_m;
                c_m = 1'b0;
            end
            8'h80: bad = 1'b1;
            default: case (op[7:4])
                4'h2: {c_m, acc_m} = acc_m + src;
                4'h3: {c_m, acc_m} = acc_m + src + c_m;
                4'h9: {c_m, acc_m} = {1'b0, acc_m} - src - c_m;
                default: acc_m = acc_m ^ src;
            endcase
        endcase
        notes.push_back({bad, acc_m, c_m, nb, nc, b_m, ram_m[o1 & 8'h7f]});
        start = 1'b1;
        opcode = op;
        operand1 = o1;
        operand2 = o2;
        pc_next = 16'($urandom);
        peek_addr = o1 & 8'h7f;
        @(negedge clock);
        opcode = 8'h80;
        load_en = 1'b1;
        load_addr = 8'he0;
        @(negedge clock);
        start = 1'b0;
        load_en = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ------
    // Processes
    // ------
    initial forever begin
        @(negedge clock);
        if (done === 1'b1) begin
            exp_v = notes.pop_front();
            seen = {bad_opcode, acc, psw[7], instr_bytes, instr_cycles, b_reg, 8'h00};
            @(negedge clock);
            check({seen[30:8], peek_data}, exp_v);
        end
    end
    initial begin
        #100000;
        failures++;
        report_and_stop();
    end
    initial begin
        void'($urandom(19));
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        check(31'({acc, b_reg, psw, busy, done}), 31'h0);
        check(31'(data_pointer_reg), 31'h0);
        $display("reset test done");
        for (int i = 0; i < 128; i++) begin
            d = (i < 2) ? 8'($urandom % 128) : 8'($urandom);
            load(8'(i), d);
            ram_m[i] = d;
        end
        acc_m = 8'($urandom);
        b_m = 8'($urandom);
        c_m = 1'($urandom);
        load(8'he0, acc_m);
        load(8'hf0, b_m);
        load(8'hd0, {c_m, 7'h00});
        @(negedge clock);
        load_en = 1'b0;
        repeat (3) foreach (ops[k]) issue(ops[k]);
        $display("opcode table test done");
        repeat (40) issue(ops[$urandom % 21]);
        repeat (2) @(negedge clock);
        check(31'(notes.size()), 31'h0);
        $display("random opcode test done");
        report_and_stop();
    end
endmodule
bind arith_logic_instruction_unit alu_port_checker chk (.clock(clock), .rst(rst), .start(start),
    .opcode(opcode), .operand1(operand1), .pc_next(pc_next), .busy(busy), .done(done),
    .instr_bytes(instr_bytes), .instr_cycles(instr_cycles), .rel_target(rel_target),
    .acc(acc), .psw(psw));
